/* fccd_consts.svh */
`ifndef FCCD_CONSTS_SVH
`define FCCD_CONSTS_SVH
// APB register byte offsets
`define FCCD_OFF_DATA 12'h000
`define FCCD_OFF_STAT 12'h004
`define FCCD_OFF_IMASK 12'h008
`define FCCD_OFF_ISTAT 12'h00C
`define FCCD_OFF_DSTAT 12'h010
`define FCCD_OFF_PINS 12'h014
// Opcodes
`define FCCD_OP_SPECIFY 8'h03
`define FCCD_OP_SENSE_DRV 8'h04
`define FCCD_OP_RECAL 8'h07
`define FCCD_OP_SENSE_INT 8'h08
`define FCCD_OP_DUMP 8'h0E
`define FCCD_OP_SEEK 8'h0F
`define FCCD_OP_VERSION 8'h10
`define FCCD_OP_PERP 8'h12
`define FCCD_OP_CONFIGURE 8'h13
`define FCCD_REL_MASK 8'hBF
`define FCCD_OP_REL 8'h8F
`define FCCD_LOCK_MASK 8'h7F
`define FCCD_OP_LOCK 8'h14
// Status byte zero values
`define FCCD_SBZ_INVALID 8'h80
`define FCCD_SBZ_SEEK_END 8'h20
`define FCCD_SBZ_NO_INT 8'h80
// Reset values, default step time, clock period and dump length
`define FCCD_CFG_RESET 8'h20
`define FCCD_PRECOMP_RESET 8'h00
`define FCCD_STEP_TIME_NS 3000
`define FCCD_CLK_NS 25
`define FCCD_DUMP_LEN 4'hA
// Interrupt status bits
`define FCCD_IRQ_SEEK 0
`define FCCD_IRQ_INVALID 1
`define FCCD_IRQ_RESULT 2
`endif

/* fccd_pkg.sv */
package fccd_pkg;
   typedef enum logic [1:0] {fccd_dir_out, fccd_dir_in, fccd_dir_idle} fccd_dir_e;
   typedef struct packed {
      logic [3:0] step_rate_time;
      logic [3:0] head_unload_time;
      logic [6:0] head_load_time;
      logic no_dma_select;
   } fccd_spec_s;
   typedef struct packed {
      logic lock;
      logic overwrite_enable;
      logic [3:0] perp_sel;
      logic gap;
      logic write_gate_timing;
      logic [7:0] cfg;
      logic [7:0] precomp_start_track;
   } fccd_set_s;
   typedef struct packed {
      logic step;
      logic dir_in;
      logic [1:0] drive;
      logic head;
   } fccd_head_s;
endpackage : fccd_pkg

/* fccd_result_mem.sv */
`timescale 1ns/10ps
module fccd_result_mem #(
   parameter int DEPTH = 16
) (
   // Clock
   input wire logic pclk,
   // Write side
   input wire logic wr_en,
   input wire logic [3:0] wr_addr,
   input wire logic [7:0] wr_data,
   // Read side
   input wire logic [3:0] rd_addr,
   output logic [7:0] rd_data
);
   logic [7:0] mem [DEPTH];
   if (DEPTH < 10 || DEPTH > 16)
   begin : g_bad_depth
      $error("fccd_result_mem depth out of range");
   end
   always_ff @(posedge pclk)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule : fccd_result_mem

/* fccd_stepper.sv */
`timescale 1ns/10ps
module fccd_stepper #(
   parameter int STEP_CYCLES = 120
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Request
   input wire logic start,
   input wire logic dir_in,
   input wire logic [7:0] count,
   input wire logic to_track0,
   input wire logic track0,
   // Status
   output logic busy,
   output logic step_pulse,
   output logic done
);
   logic [15:0] tmr_q, tmr_d;
   logic [7:0] left_q, left_d;
   logic busy_q, busy_d, zero_q, zero_d, pulse_d, done_d;
   if (STEP_CYCLES < 2 || STEP_CYCLES > 65535)
   begin : g_bad_step
      $error("fccd_stepper step cycles out of range");
   end
   always_comb
   begin
      tmr_d = tmr_q;
      left_d = left_q;
      busy_d = busy_q;
      zero_d = zero_q;
      pulse_d = 1'b0;
      done_d = 1'b0;
      if (start && !busy_q)
      begin
         busy_d = 1'b1;
         left_d = count;
         zero_d = to_track0;
         tmr_d = 16'h0000;
      end
      else if (busy_q)
      begin
         if (tmr_q != 16'h0000)
         begin
            tmr_d = tmr_q - 16'h0001;
         end
         else if ((zero_q && track0) || (!zero_q && left_q == 8'h00))
         begin
            busy_d = 1'b0;
            done_d = 1'b1;
         end
         else
         begin
            pulse_d = 1'b1;
            tmr_d = 16'(STEP_CYCLES - 1);
            if (!zero_q)
            begin
               left_d = left_q - 8'h01;
            end
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tmr_q <= 16'h0000;
         left_q <= 8'h00;
         busy_q <= 1'b0;
         zero_q <= 1'b0;
         step_pulse <= 1'b0;
         done <= 1'b0;
      end
      else
      begin
         tmr_q <= tmr_d;
         left_q <= left_d;
         busy_q <= busy_d;
         zero_q <= zero_d;
         step_pulse <= pulse_d;
         done <= done_d;
      end
   end
   assign busy = busy_q;
endmodule : fccd_stepper

/* fccd_decoder.sv */
`timescale 1ns/10ps
`include "fccd_consts.svh"
// Functional notes
// - Recalibrate (07h) plus a drive byte steps that drive outward until it reports cylinder 0.
// - Seek (0Fh) takes a drive/head byte then a target cylinder and moves the head there.
// - Relative seek (bit7 set, bit6 direction, low bits 001111) steps in or out by the third byte.
// - Dump (0Eh) queues ten result bytes: four present cylinders, timing, lock/perpendicular, config, precomp track.
// - Sense interrupt status (08h) first returns status byte zero of the finished positioning operation.
// - Sense interrupt status then returns the present cylinder of the drive that finished.
// - Sense drive status (04h) plus a drive/head byte returns one drive status byte.
module fccd_decoder #(
   parameter logic [7:0] VERSION_ID = 8'h5A, // Arbitrary value
   parameter int STEP_TIME_NS = `FCCD_STEP_TIME_NS
) (
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Drive side
   input wire logic track0,
   input wire logic [7:0] drive_status_in,
   output fccd_pkg::fccd_head_s head_ctl,
   // Interrupt
   output logic irq
);
   localparam int STEP_CYCLES = (STEP_TIME_NS + `FCCD_CLK_NS - 1) / `FCCD_CLK_NS;
   typedef enum logic [2:0] {fccd_idle, fccd_params, fccd_exec, fccd_wait_step, fccd_result} fccd_state_e;

   fccd_state_e st_q, st_d;
   logic [7:0] op_q, op_d;
   logic [1:0] pidx_q, pidx_d;
   logic [7:0] sel_q, sel_d;
   logic [7:0] present_cylinder_q [4];
   logic [7:0] present_cylinder_d [4];
   logic [7:0] target_cylinder_q, target_cylinder_d;
   logic [7:0] status_byte_zero_q, status_byte_zero_d;
   logic [1:0] done_drive_q, done_drive_d;
   logic int_pend_q, int_pend_d;
   fccd_pkg::fccd_spec_s spec_q, spec_d;
   fccd_pkg::fccd_set_s set_q, set_d;
   logic [3:0] rlen_q, rlen_d, rptr_q, rptr_d, wptr_q, wptr_d;
   logic rvalid_q, rvalid_d;
   logic [2:0] imask_q, imask_d, istat_q, istat_d;
   logic [31:0] prdata_d;
   logic irq_d, pready_d, pslverr_d;
   fccd_pkg::fccd_head_s head_d;
   logic mem_we;
   logic [7:0] mem_wd, mem_rd;
   logic st_start, st_dir, st_zero, st_busy, st_pulse, st_done;
   logic [7:0] st_count;
   logic [2:0] ev;
   logic acc, wr, rd, data_wr, data_rd;
   logic [7:0] wbyte;
   logic [1:0] need;

   fccd_result_mem #(.DEPTH(16)) u_mem (
      .pclk(pclk),
      .wr_en(mem_we),
      .wr_addr(wptr_q),
      .wr_data(mem_wd),
      .rd_addr(rptr_d),
      .rd_data(mem_rd)
   );

   fccd_stepper #(.STEP_CYCLES(STEP_CYCLES)) u_step (
      .pclk(pclk),
      .presetn(presetn),
      .start(st_start),
      .dir_in(st_dir),
      .count(st_count),
      .to_track0(st_zero),
      .track0(track0),
      .busy(st_busy),
      .step_pulse(st_pulse),
      .done(st_done)
   );

   assign acc = psel && penable && !pready;
   assign wr = acc && pwrite;
   assign rd = acc && !pwrite;
   assign wbyte = pwdata[7:0];
   assign data_wr = wr && paddr == `FCCD_OFF_DATA;
   assign data_rd = rd && paddr == `FCCD_OFF_DATA;

   // Parameter bytes following each opcode
   always_comb
   begin
      case (op_q)
         `FCCD_OP_SPECIFY: need = 2'd2;
         `FCCD_OP_SENSE_DRV: need = 2'd1;
         `FCCD_OP_RECAL: need = 2'd1;
         `FCCD_OP_SEEK: need = 2'd2;
         `FCCD_OP_PERP: need = 2'd1;
         `FCCD_OP_CONFIGURE: need = 2'd3;
         default: need = ((op_q & `FCCD_REL_MASK) == `FCCD_OP_REL) ? 2'd2 : 2'd0;
      endcase
   end

   // Command sequencer
   always_comb
   begin
      st_d = st_q;
      op_d = op_q;
      pidx_d = pidx_q;
      sel_d = sel_q;
      present_cylinder_d = present_cylinder_q;
      target_cylinder_d = target_cylinder_q;
      status_byte_zero_d = status_byte_zero_q;
      done_drive_d = done_drive_q;
      int_pend_d = int_pend_q;
      spec_d = spec_q;
      set_d = set_q;
      rlen_d = rlen_q;
      rptr_d = rptr_q;
      wptr_d = wptr_q;
      rvalid_d = rvalid_q;
      mem_we = 1'b0;
      mem_wd = 8'h00;
      st_start = 1'b0;
      st_dir = 1'b0;
      st_zero = 1'b0;
      st_count = 8'h00;
      ev = 3'b000;
      head_d = '0;
      head_d.drive = sel_q[1:0];
      head_d.head = sel_q[2];
      head_d.dir_in = head_ctl.dir_in;
      case (st_q)
         fccd_idle:
         begin
            if (data_wr)
            begin
               op_d = wbyte;
               pidx_d = 2'd0;
               wptr_d = 4'h0;
               st_d = fccd_params;
            end
         end
         fccd_params:
         begin
            if (need == 2'd0 || pidx_q == need)
            begin
               st_d = fccd_exec;
            end
            else if (data_wr)
            begin
               pidx_d = pidx_q + 2'd1;
               case (op_q)
                  `FCCD_OP_SPECIFY:
                  begin
                     if (pidx_q == 2'd0)
                     begin
                        spec_d.step_rate_time = wbyte[7:4];
                        spec_d.head_unload_time = wbyte[3:0];
                     end
                     else
                     begin
                        spec_d.head_load_time = wbyte[7:1];
                        spec_d.no_dma_select = wbyte[0];
                     end
                  end
                  `FCCD_OP_PERP:
                  begin
                     set_d.overwrite_enable = wbyte[7];
                     if (wbyte[7])
                     begin
                        set_d.perp_sel = wbyte[5:2];
                     end
                     set_d.gap = wbyte[1];
                     set_d.write_gate_timing = wbyte[0];
                  end
                  `FCCD_OP_CONFIGURE:
                  begin
                     if (pidx_q == 2'd1)
                     begin
                        set_d.cfg = wbyte;
                     end
                     else if (pidx_q == 2'd2)
                     begin
                        set_d.precomp_start_track = wbyte;
                     end
                  end
                  default:
                  begin
                     if (pidx_q == 2'd0)
                     begin
                        sel_d = wbyte;
                     end
                     else
                     begin
                        target_cylinder_d = wbyte;
                     end
                  end
               endcase
            end
         end
         fccd_exec:
         begin
            st_d = fccd_result;
            rptr_d = 4'h0;
            rvalid_d = 1'b0;
            mem_we = 1'b1;
            rlen_d = 4'h1;
            wptr_d = wptr_q + 4'h1;
            case (op_q)
               `FCCD_OP_RECAL:
               begin
                  st_start = 1'b1;
                  st_zero = 1'b1;
                  head_d.dir_in = 1'b0;
                  mem_we = 1'b0;
                  st_d = fccd_wait_step;
               end
               `FCCD_OP_SEEK:
               begin
                  st_start = 1'b1;
                  st_dir = target_cylinder_q > present_cylinder_q[sel_q[1:0]];
                  head_d.dir_in = st_dir;
                  st_count = st_dir ? target_cylinder_q - present_cylinder_q[sel_q[1:0]]
                                    : present_cylinder_q[sel_q[1:0]] - target_cylinder_q;
                  mem_we = 1'b0;
                  st_d = fccd_wait_step;
               end
               `FCCD_OP_DUMP:
               begin
                  if (wptr_q < 4'h4)
                  begin
                     mem_wd = present_cylinder_q[wptr_q[1:0]];
                  end
                  else
                  begin
                     case (wptr_q)
                        4'h4: mem_wd = {spec_q.step_rate_time, spec_q.head_unload_time};
                        4'h5: mem_wd = {spec_q.head_load_time, spec_q.no_dma_select};
                        4'h6: mem_wd = 8'h00;
                        4'h7: mem_wd = {set_q.lock, 1'b0, set_q.perp_sel, set_q.gap, set_q.write_gate_timing};
                        4'h8: mem_wd = set_q.cfg;
                        default: mem_wd = set_q.precomp_start_track;
                     endcase
                  end
                  rlen_d = `FCCD_DUMP_LEN;
                  if (wptr_q != `FCCD_DUMP_LEN - 4'h1)
                  begin
                     st_d = fccd_exec;
                  end
               end
               `FCCD_OP_SENSE_INT:
               begin
                  mem_wd = int_pend_q ? status_byte_zero_q : `FCCD_SBZ_NO_INT;
                  if (int_pend_q)
                  begin
                     rlen_d = 4'h2;
                     if (wptr_q == 4'h0)
                     begin
                        st_d = fccd_exec;
                     end
                     else
                     begin
                        mem_wd = present_cylinder_q[done_drive_q];
                        int_pend_d = 1'b0;
                     end
                  end
               end
               `FCCD_OP_SENSE_DRV:
               begin
                  mem_wd = {drive_status_in[7:5], track0, drive_status_in[3], sel_q[2:0]};
               end
               `FCCD_OP_VERSION:
               begin
                  mem_wd = VERSION_ID;
               end
               `FCCD_OP_SPECIFY, `FCCD_OP_PERP, `FCCD_OP_CONFIGURE:
               begin
                  mem_we = 1'b0;
                  st_d = fccd_idle;
               end
               default:
               begin
                  if ((op_q & `FCCD_REL_MASK) == `FCCD_OP_REL)
                  begin
                     st_start = 1'b1;
                     st_dir = op_q[6];
                     head_d.dir_in = op_q[6];
                     st_count = target_cylinder_q;
                     mem_we = 1'b0;
                     st_d = fccd_wait_step;
                  end
                  else if ((op_q & `FCCD_LOCK_MASK) == `FCCD_OP_LOCK)
                  begin
                     set_d.lock = op_q[7];
                     mem_wd = {3'b000, op_q[7], 4'h0};
                  end
                  else
                  begin
                     mem_wd = `FCCD_SBZ_INVALID;
                     ev[`FCCD_IRQ_INVALID] = 1'b1;
                  end
               end
            endcase
         end
         fccd_wait_step:
         begin
            head_d.step = st_pulse;
            if (st_pulse)
            begin
               if (op_q == `FCCD_OP_RECAL)
               begin
                  present_cylinder_d[sel_q[1:0]] = present_cylinder_q[sel_q[1:0]] - 8'h01;
               end
               else if (head_ctl.dir_in)
               begin
                  present_cylinder_d[sel_q[1:0]] = present_cylinder_q[sel_q[1:0]] + 8'h01;
               end
               else
               begin
                  present_cylinder_d[sel_q[1:0]] = present_cylinder_q[sel_q[1:0]] - 8'h01;
               end
            end
            if (st_done)
            begin
               if (op_q == `FCCD_OP_RECAL)
               begin
                  present_cylinder_d[sel_q[1:0]] = 8'h00;
               end
               status_byte_zero_d = `FCCD_SBZ_SEEK_END | {5'h00, sel_q[2:0]};
               done_drive_d = sel_q[1:0];
               int_pend_d = 1'b1;
               ev[`FCCD_IRQ_SEEK] = 1'b1;
               st_d = fccd_idle;
            end
         end
         fccd_result:
         begin
            if (!rvalid_q)
            begin
               rvalid_d = 1'b1;
               ev[`FCCD_IRQ_RESULT] = 1'b1;
            end
            else if (data_rd)
            begin
               rptr_d = rptr_q + 4'h1;
               if (rptr_q == rlen_q - 4'h1)
               begin
                  rvalid_d = 1'b0;
                  st_d = fccd_idle;
               end
            end
         end
         default:
         begin
            st_d = fccd_idle;
         end
      endcase
   end

   // Register bus and interrupt status
   always_comb
   begin
      imask_d = imask_q;
      istat_d = istat_q;
      prdata_d = prdata;
      pready_d = acc;
      pslverr_d = 1'b0;
      if (wr && paddr == `FCCD_OFF_IMASK)
      begin
         imask_d = pwdata[2:0];
      end
      if (rd)
      begin
         case (paddr)
            `FCCD_OFF_DATA: prdata_d = {24'h0, (st_q == fccd_result && rvalid_q) ? mem_rd : 8'h00};
            `FCCD_OFF_STAT: prdata_d = {27'h0, st_busy, st_q == fccd_result && rvalid_q,
                                        st_q == fccd_idle, int_pend_q, st_q != fccd_idle};
            `FCCD_OFF_IMASK: prdata_d = {29'h0, imask_q};
            `FCCD_OFF_ISTAT:
            begin
               prdata_d = {29'h0, istat_q};
               istat_d = 3'b000;
            end
            `FCCD_OFF_DSTAT: prdata_d = {8'h00, set_q.precomp_start_track, set_q.cfg,
                                         spec_q.step_rate_time, spec_q.head_unload_time};
            `FCCD_OFF_PINS: prdata_d = {24'h0, present_cylinder_q[sel_q[1:0]]};
            default:
            begin
               prdata_d = 32'h0;
               pslverr_d = 1'b1;
            end
         endcase
      end
      else if (wr && !(paddr == `FCCD_OFF_DATA || paddr == `FCCD_OFF_IMASK))
      begin
         pslverr_d = 1'b1;
      end
      istat_d = istat_d | ev;
      irq_d = |(istat_d & imask_d);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_q <= fccd_idle;
         op_q <= 8'h00;
         pidx_q <= 2'd0;
         sel_q <= 8'h00;
         for (int i = 0; i < 4; i++)
         begin
            present_cylinder_q[i] <= 8'h00;
         end
         target_cylinder_q <= 8'h00;
         status_byte_zero_q <= 8'h00;
         done_drive_q <= 2'd0;
         int_pend_q <= 1'b0;
         spec_q <= '0;
         set_q <= '{lock: 1'b0, overwrite_enable: 1'b0, perp_sel: 4'h0, gap: 1'b0, write_gate_timing: 1'b0,
                    cfg: `FCCD_CFG_RESET, precomp_start_track: `FCCD_PRECOMP_RESET};
         rlen_q <= 4'h0;
         rptr_q <= 4'h0;
         wptr_q <= 4'h0;
         rvalid_q <= 1'b0;
         imask_q <= 3'b000;
         istat_q <= 3'b000;
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         irq <= 1'b0;
         head_ctl <= '0;
      end
      else
      begin
         st_q <= st_d;
         op_q <= op_d;
         pidx_q <= pidx_d;
         sel_q <= sel_d;
         present_cylinder_q <= present_cylinder_d;
         target_cylinder_q <= target_cylinder_d;
         status_byte_zero_q <= status_byte_zero_d;
         done_drive_q <= done_drive_d;
         int_pend_q <= int_pend_d;
         spec_q <= spec_d;
         set_q <= set_d;
         rlen_q <= rlen_d;
         rptr_q <= rptr_d;
         wptr_q <= wptr_d;
         rvalid_q <= rvalid_d;
         imask_q <= imask_d;
         istat_q <= istat_d;
         prdata <= prdata_d;
         pready <= pready_d;
         pslverr <= pslverr_d;
         irq <= irq_d;
         head_ctl <= head_d;
      end
   end
endmodule : fccd_decoder

/* fccd_props.sv */
`timescale 1ns/10ps
module fccd_props (
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Drive side and interrupt
   input wire logic track0,
   input wire logic [7:0] drive_status_in,
   input wire fccd_pkg::fccd_head_s head_ctl,
   input wire logic irq
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic ro_q;
   assign ro_q = paddr == 12'h004 || paddr == 12'h00C || paddr == 12'h010 || paddr == 12'h014;
   property p_rdy_pulse; pready |=> !pready; endproperty
   a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready held too long");
   property p_rdy_due; psel && penable && !pready |=> pready; endproperty
   a_rdy_due: assert property (p_rdy_due) else $error("pready late");
   property p_rdy_cause; pready |-> $past(psel) && $past(penable); endproperty
   a_rdy_cause: assert property (p_rdy_cause) else $error("pready without access");
   property p_err_rdy; pslverr |-> pready; endproperty
   a_err_rdy: assert property (p_err_rdy) else $error("pslverr without pready");
   property p_unmap; pready && !pwrite && paddr > 12'h014 |-> pslverr && prdata == 32'h00000000; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
   property p_ro_wr; pready && pwrite && ro_q |-> pslverr; endproperty
   a_ro_wr: assert property (p_ro_wr) else $error("read-only write not refused");
   property p_data_hi; pready && !pwrite && paddr == 12'h000 |-> prdata[31:8] == 24'h000000; endproperty
   a_data_hi: assert property (p_data_hi) else $error("data upper bits set");
   property p_step_gap; head_ctl.step |=> !head_ctl.step [*5]; endproperty
   a_step_gap: assert property (p_step_gap) else $error("steps too close");
   c_step: cover property (head_ctl.step && head_ctl.dir_in);
   c_err: cover property (pslverr);
   c_irq: cover property ($rose(irq));
endmodule : fccd_props
bind fccd_decoder fccd_props i_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
   .pready, .pslverr, .track0, .drive_status_in, .head_ctl, .irq);

/* fccd_drive_model.sv */
`timescale 1ns/10ps
module fccd_drive_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Head control in, cylinder 0 sense out
   input wire fccd_pkg::fccd_head_s head_ctl,
   output logic track0
);
   logic [7:0] cyl_q [4];
   // Head stops at cylinder 0
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cyl_q <= '{default: 8'h00};
      end
      else if (head_ctl.step && head_ctl.dir_in)
      begin
         cyl_q[head_ctl.drive] <= cyl_q[head_ctl.drive] + 8'h01;
      end
      else if (head_ctl.step && cyl_q[head_ctl.drive] != 8'h00)
      begin
         cyl_q[head_ctl.drive] <= cyl_q[head_ctl.drive] - 8'h01;
      end
   end
   assign track0 = cyl_q[head_ctl.drive] == 8'h00;
endmodule : fccd_drive_model

/* tb_top.sv */
`timescale 1ns/10ps
`include "fccd_consts.svh"
module tb_top;
   localparam logic [7:0] VER = 8'h5A; // Arbitrary value
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic track0;
   logic [7:0] drive_status_in = 8'hE8;
   fccd_pkg::fccd_head_s head_ctl;
   logic irq;
   logic [31:0] rv;
   logic ev;
   logic [7:0] dmp [10] = '{8'h00, 8'h06, 8'h00, 8'h00, 8'hA5, 8'h0B, 8'h00, 8'h96, 8'h57, 8'h09};
   int err_total = 0;
   int n_checks = 0;
   int cyc = 0;
   always #12.5 pclk = ~pclk;
   fccd_decoder #(.VERSION_ID(VER), .STEP_TIME_NS(250)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .track0, .drive_status_in, .head_ctl, .irq);
   fccd_drive_model i_drv (.pclk, .presetn, .head_ctl, .track0);
   task automatic print_verdict();
      if (err_total == 0 && n_checks > 0)
      begin
         $display("Test passed");
      end
      else
      begin
         $display("Test failed");
      end
      $finish;
   endtask : print_verdict
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_total++;
         print_verdict();
      end
   end
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      rv = prdata;
      ev = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wait_st(input int b, input logic v);
      int n;
      n = 0;
      do
      begin
         apb(1'b0, `FCCD_OFF_STAT, 32'h0);
         n++;
      end
      while (rv[b] !== v && n < 300);
      chk("status poll", {31'h0, rv[b]}, {31'h0, v});
   endtask : wait_st
   task automatic put(input logic [7:0] b);
      apb(1'b1, `FCCD_OFF_DATA, {24'h0, b});
   endtask : put
   task automatic op(input logic [7:0] b);
      wait_st(2, 1'b1);
      put(b);
   endtask : op
   task automatic res(input logic [7:0] e);
      wait_st(3, 1'b1);
      apb(1'b0, `FCCD_OFF_DATA, 32'h0);
      chk("result byte", rv, {24'h0, e});
   endtask : res
   // Positioning command, then sense interrupt status
   task automatic mv(input logic [7:0] o, input logic [7:0] s, input logic [7:0] n, input logic [7:0] st0,
      input logic [7:0] present_cylinder);
      op(o);
      put(s);
      if (o != `FCCD_OP_RECAL)
      begin
         put(n);
      end
      wait_st(1, 1'b1);
      op(`FCCD_OP_SENSE_INT);
      res(st0);
      res(present_cylinder);
      chk("drive cylinder", {24'h0, i_drv.cyl_q[s[1:0]]}, {24'h0, present_cylinder});
   endtask : mv
   task automatic t_regs();
      apb(1'b0, `FCCD_OFF_DSTAT, 32'h0);
      chk("reset settings", rv, 32'h00002000);
      apb(1'b0, 12'h018, 32'h0);
      chk("unmapped err", {31'h0, ev}, 32'h1);
      chk("unmapped data", rv, 32'h0);
      apb(1'b1, `FCCD_OFF_STAT, 32'hFF);
      chk("read-only err", {31'h0, ev}, 32'h1);
   endtask : t_regs
   task automatic t_id_inv();
      op(`FCCD_OP_VERSION);
      res(VER);
      op(8'h01);
      res(`FCCD_SBZ_INVALID);
      apb(1'b0, `FCCD_OFF_ISTAT, 32'h0);
      chk("invalid event", {31'h0, rv[1]}, 32'h1);
   endtask : t_id_inv
   task automatic t_seek();
      apb(1'b1, `FCCD_OFF_IMASK, 32'h1);
      mv(`FCCD_OP_SEEK, 8'h05, 8'h07, 8'h25, 8'h07);
      chk("irq raised", {31'h0, irq}, 32'h1);
      apb(1'b0, `FCCD_OFF_ISTAT, 32'h0);
      chk("seek event", {31'h0, rv[0]}, 32'h1);
      repeat (2) @(posedge pclk);
      chk("irq cleared", {31'h0, irq}, 32'h0);
      op(`FCCD_OP_SENSE_INT);
      res(`FCCD_SBZ_NO_INT);
      mv(8'h8F, 8'h01, 8'h03, 8'h21, 8'h04);
      mv(8'hCF, 8'h01, 8'h02, 8'h21, 8'h06);
      apb(1'b0, `FCCD_OFF_PINS, 32'h0);
      chk("present cylinder", rv, 32'h6);
   endtask : t_seek
   task automatic t_set();
      op(`FCCD_OP_SPECIFY);
      put(8'hA5);
      put(8'h0B);
      op(`FCCD_OP_CONFIGURE);
      put(8'h00);
      put(8'h57);
      put(8'h09);
      op(`FCCD_OP_PERP);
      put(8'h96);
      op(8'h94);
      res(8'h10);
      apb(1'b0, `FCCD_OFF_DSTAT, 32'h0);
      chk("stored settings", rv, 32'h000957A5);
      op(`FCCD_OP_DUMP);
      for (int i = 0; i < 10; i++)
      begin
         res(dmp[i]);
      end
      op(8'h14);
      res(8'h00);
   endtask : t_set
   initial
   begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_id_inv();
      t_seek();
      t_set();
      mv(`FCCD_OP_RECAL, 8'h01, 8'h00, 8'h21, 8'h00);
      op(`FCCD_OP_SENSE_DRV);
      put(8'h01);
      res(8'hF9);
      print_verdict();
   end
endmodule : tb_top
